// ===== hdl/sdb_notify_map.vh
// register offsets, field positions, reset values for the notification latch block
`ifndef SDB_NOTIFY_MAP_VH
`define SDB_NOTIFY_MAP_VH

`define ADDR_NOTIFY_LATCH     4'h0
`define ADDR_INTR_STATUS      4'h1
`define ADDR_INTR_CLEAR       4'h2
`define ADDR_INTR_ENABLE      4'h3
`define ADDR_PORT_CTRL        4'h4
`define ADDR_CAPABILITY       4'h5
`define ADDR_TASK_FILE        4'h6
`define ADDR_ACTIVE_TAGS      4'h7
`define ADDR_LAST_FIS         4'h8

`define INTR_SDB_BIT          0
`define INTR_WRONG_TGT_BIT    1
`define INTR_WIDTH            2

`define CTRL_ACCESS_LSB       0
`define CTRL_FBS_BIT          4
`define CAP_NOTIFY_BIT        0

`define FIS_TYPE_SDB          8'hA1
`define FIS_TYPE_LSB          0
`define FIS_PORT_LSB          8
`define FIS_INTR_BIT          14
`define FIS_NOTIFY_BIT        15
`define FIS_STATUS_LSB        16
`define FIS_ERROR_LSB         24

`define NOTIFY_RESET          16'h0000
`define CTRL_RESET            5'h00
`define TFD_RESET             16'h007f
`define ACTIVE_RESET          32'h0000_0000
`define READ_UNMAPPED         32'h0000_0000

`endif

// ===== hdl/fis_header_decode.v
// first-doubleword decoder for received frames
`timescale 1ns/1ns
module fis_header_decode
(
    // first doubleword of a received frame
    input  wire [31:0] dword0,
    // decoded fields
    output wire        is_sdb,
    output wire [3:0]  target_port_field,
    output wire        intr_bit,
    output wire        notify_bit
);
`include "sdb_notify_map.vh"

    assign is_sdb            = (dword0[`FIS_TYPE_LSB+7:`FIS_TYPE_LSB] == `FIS_TYPE_SDB);
    assign target_port_field = dword0[`FIS_PORT_LSB+3:`FIS_PORT_LSB];
    assign intr_bit          = dword0[`FIS_INTR_BIT];
    assign notify_bit        = dword0[`FIS_NOTIFY_BIT];

endmodule

// ===== hdl/sdb_notification_latch.v
// set device bits notification latch, interrupt status and frame filter
// Behaviour
// - take four-bit target field from dword 0
// - notifying sdb sets latch bit of target
// - processed or notifying sdb with interrupt bit sets sdb flag
// - interrupt output only when enabled
// - no multiplier: target zero sets bit 0
// - command switching drops mismatching target frames
// - notifying sdb latches despite target mismatch
// - mismatched notify: no wrong flag, discard
// - matching notify sdb processed fully
// - non-notify sdb uses ordinary mode handling
// - sixteen-bit latch, one bit per target
// - capability bit reports latch supported
`timescale 1ns/1ns
module sdb_notification_latch
(
    // clock and reset
    input  wire        mclk,
    input  wire        srst,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // received frames, first doubleword and sdb payload
    input  wire        fis_valid,
    input  wire [31:0] fis_dword0,
    input  wire [31:0] fis_dword1,
    // frame disposition
    output reg         fis_accept,
    output reg         fis_discard,
    // interrupt
    output wire        irq
);
`include "sdb_notify_map.vh"

    wire        is_sdb;
    wire [3:0]  target_port_field;
    wire        intr_bit;
    wire        notify_bit;

    fis_header_decode fis_header_decode_inst
    (
        .dword0            (fis_dword0),
        .is_sdb            (is_sdb),
        .target_port_field (target_port_field),
        .intr_bit          (intr_bit),
        .notify_bit        (notify_bit)
    );

    reg  [15:0]             notify_latch_reg;
    reg  [15:0]             notify_latch_next;
    reg  [`INTR_WIDTH-1:0]  intr_status_reg;
    reg  [`INTR_WIDTH-1:0]  intr_status_next;
    reg  [`INTR_WIDTH-1:0]  intr_enable_reg;
    reg  [4:0]              port_ctrl_reg;
    reg  [15:0]             task_file_shadow;
    reg  [31:0]             active_tag_map;
    reg  [31:0]             last_fis_reg;

    wire [3:0]  access_target = port_ctrl_reg[`CTRL_ACCESS_LSB+3:`CTRL_ACCESS_LSB];
    wire        fbs_mode      = port_ctrl_reg[`CTRL_FBS_BIT];
    wire        notify_supported = 1'b1;
    wire        target_match  = (target_port_field == access_target);
    wire        sdb_notify    = fis_valid & is_sdb & notify_bit;

    // frame is processed: fbs mode takes all targets, command mode only the accessed one
    wire        process_fis   = fis_valid & (fbs_mode | target_match);
    // notifying frame from elsewhere is quietly dropped, never flagged as wrong target
    wire        wrong_target  = fis_valid & ~fbs_mode & ~target_match & ~sdb_notify;
    wire        sdb_processed = process_fis & is_sdb;
    // notification with its interrupt bit raises the sdb flag even when the frame is dropped
    wire        sdb_intr_evt  = fis_valid & is_sdb & intr_bit & (sdb_notify | process_fis);

    wire        clear_wr      = reg_wr & (reg_addr == `ADDR_INTR_CLEAR);
    wire        latch_wr      = reg_wr & (reg_addr == `ADDR_NOTIFY_LATCH);

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_latch
            // set beats a same-cycle software clear; write one clears
            always @*
            begin
                notify_latch_next[g] = notify_latch_reg[g];
                if (latch_wr & reg_wdata[g])
                    notify_latch_next[g] = 1'b0;
                if (sdb_notify & (target_port_field == g))
                    notify_latch_next[g] = 1'b1;
            end
        end
    endgenerate

    always @*
    begin
        intr_status_next = intr_status_reg;
        if (clear_wr)
            intr_status_next = intr_status_reg & ~reg_wdata[`INTR_WIDTH-1:0];
        if (sdb_intr_evt)
            intr_status_next[`INTR_SDB_BIT] = 1'b1;
        if (wrong_target)
            intr_status_next[`INTR_WRONG_TGT_BIT] = 1'b1;
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            notify_latch_reg <= `NOTIFY_RESET;
            intr_status_reg  <= {`INTR_WIDTH{1'b0}};
            intr_enable_reg  <= {`INTR_WIDTH{1'b0}};
            port_ctrl_reg    <= `CTRL_RESET;
            task_file_shadow <= `TFD_RESET;
            active_tag_map   <= `ACTIVE_RESET;
            last_fis_reg     <= 32'h0000_0000;
        end
        else
        begin
            notify_latch_reg <= notify_latch_next;
            intr_status_reg  <= intr_status_next;
            if (reg_wr & (reg_addr == `ADDR_INTR_ENABLE))
                intr_enable_reg <= reg_wdata[`INTR_WIDTH-1:0];
            if (reg_wr & (reg_addr == `ADDR_PORT_CTRL))
                port_ctrl_reg <= reg_wdata[4:0];
            if (reg_wr & (reg_addr == `ADDR_ACTIVE_TAGS))
                active_tag_map <= reg_wdata;
            // only a processed frame touches shadow, tag map and posted copy
            if (process_fis)
                last_fis_reg <= fis_dword0;
            if (sdb_processed)
            begin
                task_file_shadow <= {fis_dword0[`FIS_ERROR_LSB+7:`FIS_ERROR_LSB],
                                     fis_dword0[`FIS_STATUS_LSB+7:`FIS_STATUS_LSB]};
                // device completions clear tags; a software write in the same cycle loses
                active_tag_map <= active_tag_map & ~fis_dword1;
            end
        end
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            fis_accept  <= 1'b0;
            fis_discard <= 1'b0;
        end
        else
        begin
            fis_accept  <= process_fis;
            fis_discard <= fis_valid & ~process_fis;
        end
    end

    always @(posedge mclk)
    begin
        if (srst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_NOTIFY_LATCH: reg_rdata <= {16'h0000, notify_latch_reg};
                `ADDR_INTR_STATUS:  reg_rdata <= {30'h0000_0000, intr_status_reg};
                `ADDR_INTR_ENABLE:  reg_rdata <= {30'h0000_0000, intr_enable_reg};
                `ADDR_PORT_CTRL:    reg_rdata <= {27'h000_0000, port_ctrl_reg};
                `ADDR_CAPABILITY:   reg_rdata <= {31'h0000_0000, notify_supported};
                `ADDR_TASK_FILE:    reg_rdata <= {16'h0000, task_file_shadow};
                `ADDR_ACTIVE_TAGS:  reg_rdata <= active_tag_map;
                `ADDR_LAST_FIS:     reg_rdata <= last_fis_reg;
                default:            reg_rdata <= `READ_UNMAPPED;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    assign irq = |(intr_status_reg & intr_enable_reg);

endmodule

// ===== dv/sdb_dev_model.sv
// frame source standing in for the attached device
`timescale 1ns/1ns
module sdb_dev_model
(
    // clock and request
    input  wire        mclk,
    input  wire        send,
    input  wire [31:0] d0_in,
    // frame header toward the port
    output reg         fis_valid  = 1'b0,
    output reg  [31:0] fis_dword0 = 32'h0000_0000,
    output reg  [31:0] fis_dword1 = 32'h0000_0000
);
    // header toggles between frames so a stale value never matches
    always @(posedge mclk)
    begin
        fis_valid  <= send;
        fis_dword0 <= send ? d0_in : ~fis_dword0;
        fis_dword1 <= send ? ~d0_in : ~fis_dword1;
    end
endmodule

// ===== dv/sdb_notify_chk.sv
// port assertions for the notification latch
`timescale 1ns/1ns
module sdb_notify_chk
(
    // clock, reset, register port
    input wire        mclk,
    input wire        srst,
    input wire [3:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // frames and interrupt
    input wire        fis_valid,
    input wire [31:0] fis_dword0,
    input wire        fis_accept,
    input wire        fis_discard,
    input wire        irq
);
    reg  [4:0] ctl_reg = 5'h00;
    reg  [1:0] en_reg  = 2'h0;
    wire       sdb     = fis_valid && fis_dword0[7:0] == 8'hA1 && fis_dword0[15];
    wire       hit     = ctl_reg[4] || fis_dword0[11:8] == ctl_reg[3:0];
    // mirrors of control and enable so filtering is predictable
    always @(posedge mclk)
    begin
        ctl_reg <= srst ? 5'h00 : (reg_wr && reg_addr == 4'h4) ? reg_wdata[4:0] : ctl_reg;
        en_reg  <= srst ? 2'h0 : (reg_wr && reg_addr == 4'h3) ? reg_wdata[1:0] : en_reg;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("rdata not idle");
    a_one_answer: assert property (fis_valid |=> fis_accept != fis_discard) else $error("bad disposition");
    a_no_spurious: assert property (!$past(fis_valid) |-> !fis_accept && !fis_discard) else $error("spurious");
    a_cmd_drop: assert property (fis_valid && !hit |=> fis_discard) else $error("kept");
    a_match_take: assert property (fis_valid && hit |=> fis_accept) else $error("dropped");
    a_notify_irq: assert property (sdb && fis_dword0[14] && en_reg[0] |=> irq) else $error("no irq");
    a_irq_masked: assert property (en_reg == 2'h0 |-> !irq) else $error("irq masked");
    a_cap_bit: assert property (reg_rd && reg_addr == 4'h5 |=> reg_rdata == 32'h0000_0001) else $error("cap");
    a_latch_set: assert property (sdb ##1 reg_rd && reg_addr == 4'h0 |=>
        reg_rdata[$past(fis_dword0[11:8], 2)]) else $error("latch bit");
    c_notify: cover property (sdb ##1 fis_discard);
    c_fbs: cover property (fis_valid && ctl_reg[4]);
    c_irq: cover property ($rose(irq));
endmodule
bind sdb_notification_latch sdb_notify_chk sdb_notify_chk_inst (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fis_valid(fis_valid),
    .fis_dword0(fis_dword0), .fis_accept(fis_accept), .fis_discard(fis_discard), .irq(irq));

// ===== dv/tb_sdb_notification_latch.sv
// self-checking bench for the notification latch
`timescale 1ns/1ns
module tb_sdb_notification_latch;
    reg         mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0, rd_d = 1'b0;
    reg  [3:0]  reg_addr  = 4'h0;
    reg  [31:0] reg_wdata = 32'h0000_0000, d0_in = 32'h0000_0000, m, s;
    wire [31:0] reg_rdata, fis_dword0, fis_dword1;
    wire        fis_valid, fis_accept, fis_discard, irq;
    integer     err_total = 0, compares = 0, t, ib;
    reg  [32:0] rq[$];
    reg  [1:0]  fq[$];
    always #10 mclk = ~mclk;
    sdb_dev_model sdb_dev_model_inst (.mclk(mclk), .send(send), .d0_in(d0_in), .fis_valid(fis_valid),
        .fis_dword0(fis_dword0), .fis_dword1(fis_dword1));
    sdb_notification_latch sdb_notification_latch_inst (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fis_valid(fis_valid),
        .fis_dword0(fis_dword0), .fis_dword1(fis_dword1), .fis_accept(fis_accept), .fis_discard(fis_discard),
        .irq(irq));
    task finish_test;
    begin
        if (rq.size() + fq.size() != 0)
            err_total = err_total + 1;
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk_rd(input [32:0] e);
    begin
        compares = compares + 1;
        if ({irq, reg_rdata} !== e)
        begin
            err_total = err_total + 1;
            $display("FAIL %0t read %h exp %h", $time, {irq, reg_rdata}, e);
        end
    end
    endtask
    task chk_fis(input [1:0] e);
    begin
        compares = compares + 1;
        if ({fis_accept, fis_discard} !== e)
        begin
            err_total = err_total + 1;
            $display("FAIL %0t frame %b exp %b", $time, {fis_accept, fis_discard}, e);
        end
    end
    endtask
    // each access leaves one idle cycle so no strobe is set twice in a step
    task wr(input [3:0] a, input [31:0] d);
    begin
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0; @(posedge mclk);
    end
    endtask
    task rd(input [3:0] a, input [32:0] e);
    begin
        reg_addr <= a; reg_rd <= 1'b1; rq.push_back(e);
        @(posedge mclk); reg_rd <= 1'b0; @(posedge mclk);
    end
    endtask
    task frm(input [3:0] tg, input ib_in, input nb, input [7:0] ty, input [1:0] e);
    begin
        d0_in <= {8'h00, 8'h50, nb, ib_in, 2'h0, tg, ty}; send <= 1'b1; fq.push_back(e);
        @(posedge mclk); send <= 1'b0; @(posedge mclk);
    end
    endtask
    always @(posedge mclk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
            chk_rd(rq.pop_front());
        if (fis_accept || fis_discard)
            chk_fis(fq.pop_front());
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_total = err_total + 1;
        finish_test;
    end
    initial
    begin
        t = $urandom(6);
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(4'h5, 33'h0_0000_0001);
        rd(4'hC, 33'h0_0000_0000);
        wr(4'h7, 32'hFFFF_FFFF);
        wr(4'h3, 32'h0000_0001);
        wr(4'h4, 32'h0000_0005);
        frm(4'h0, 1'b1, 1'b1, 8'hA1, 2'h1);
        rd(4'h1, 33'h1_0000_0001);
        rd(4'h6, 33'h1_0000_007F);
        wr(4'h2, 32'h0000_0003);
        s = 0;
        m = 1;
        for (t = 1; t < 16; t = t + 1)
        begin
            ib = (t == 5) ? 1 : $urandom % 2;
            s = s | ib;
            m = m | (32'h0000_0001 << t);
            frm(t[3:0], ib[0], 1'b1, 8'hA1, (t == 5) ? 2'h2 : 2'h1);
            rd(4'h0, {s[0], m});
        end
        rd(4'h6, 33'h1_0000_0050);
        rd(4'h7, 33'h1_0050_C5A1);
        rd(4'h8, 33'h1_0050_C5A1);
        wr(4'h0, 32'h0000_FFFF);
        wr(4'h2, 32'h0000_0003);
        frm(4'h2, 1'b1, 1'b0, 8'hA1, 2'h1);
        rd(4'h1, 33'h0_0000_0002);
        wr(4'h3, 32'h0000_0003);
        rd(4'h1, 33'h1_0000_0002);
        frm(4'h9, 1'b1, 1'b0, 8'h34, 2'h1);
        wr(4'h4, 32'h0000_0019);
        frm(4'h3, 1'b1, 1'b0, 8'hA1, 2'h2);
        rd(4'h0, 33'h1_0000_0000);
        // let the monitor take the last notes before the verdict
        repeat (3) @(posedge mclk);
        finish_test;
    end
endmodule
